// [include/pfcp_pkg.sv]
// Constants, register map and carrier types of the PFC status readback bank.
// Assumes one 25 MHz core clock and engine strobes that are one cycle long.
// How it works
// - Current offset holds deviation from mid bias; leg shunt uses mean of two channels.
// - Bus reciprocal scaled so nominal reads 4096; regulator uses it only when enabled.
// - ADC gain factor from two reference conversions, 1024 ideal, range 0 to 4095.
// - Signed ADC offset from same references, range -1024 to 1023.
// - Rectified AC voltage is absolute ADC value minus mid bias, limited to 0 to 2047.
// - AC voltage filtered at quarter PWM rate, feeds peak and voltage checks.
// - AC peak refreshed every 100 ms; feeds partial bus reference.
// - Partial mode bus reference is AC peak minus bus hysteresis.
// - Peak clamped between 1.25 times undervoltage and 0.96875 times overvoltage level.
// - PWM active only with enable set and every condition met; else gate off.
// - Active forced low by stop, blanking, short pulse command, or AC fault.
// - Blanking flag set while instantaneous AC exceeds bus, checked each PWM cycle.
// - Status bit 0 abnormal, cleared only after good time threshold of normal input.
// - Status bit 1 set after AC below undervoltage threshold for its time.
// - Status bit 2 set after AC above overvoltage threshold for its time.
// - At offset correction, store AC minus DC channel difference as AC offset.
// - AC current offset taken at first init, again if PFC stopped first.
package pfcp_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int PEAK_PERIOD_MS = 100;
  localparam int PEAK_CYCLES    = CLK_HZ / 1000 * PEAK_PERIOD_MS;
  localparam int LPF_SHIFT      = 2;
  localparam int LPF_FRAC       = 4;

  // ==========================================================
  // Scaling and limits
  localparam logic [11:0] MID_BIAS   = 12'h800;
  localparam logic [15:0] RCP_MAX    = 16'h15d5;
  localparam logic [15:0] RCP_UNITY  = 16'h1000;
  localparam logic [15:0] GAIN_MAX   = 16'h0fff;
  localparam logic [15:0] OFS_MAX    = 16'h03ff;
  localparam logic [15:0] OFS_MIN    = 16'hfc00;
  localparam logic [15:0] VAC_MAX    = 16'h07ff;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam int          ST_ABN     = 0;
  localparam int          ST_UV      = 1;
  localparam int          ST_OV      = 2;

  // ==========================================================
  // Register index
  typedef enum logic [3:0] {
    R_STATUS = 4'h0, R_FILT  = 4'h1, R_VAC   = 4'h2, R_PWMON = 4'h3,
    R_IOFS   = 4'h4, R_BLANK = 4'h5, R_PEAK  = 4'h6, R_ADOFS = 4'h7,
    R_ADGAIN = 4'h8, R_IFB   = 4'h9, R_VOFS  = 4'ha, R_AC_INPUT_CURRENT  = 4'hb,
    R_RCP    = 4'hc, R_NONE  = 4'hf
  } pfcp_reg_t;

  // Host data space byte addresses
  localparam logic [15:0] H_STATUS = 16'h80b2;
  localparam logic [15:0] H_FILT   = 16'h80dc;
  localparam logic [15:0] H_VAC    = 16'h817c;
  localparam logic [15:0] H_PWMON  = 16'h819e;
  localparam logic [15:0] H_IOFS   = 16'h81a0;
  localparam logic [15:0] H_BLANK  = 16'h81ae;
  localparam logic [15:0] H_PEAK   = 16'h827e;
  localparam logic [15:0] H_ADOFS  = 16'h82a4;
  localparam logic [15:0] H_ADGAIN = 16'h82a6;
  localparam logic [15:0] H_IFB    = 16'h82d2;
  localparam logic [15:0] H_VOFS   = 16'h836c;
  localparam logic [15:0] H_AC_INPUT_CURRENT   = 16'h8376;
  localparam logic [15:0] H_RCP    = 16'h8388;

  // Engine data space word addresses
  localparam logic [8:0] E_STATUS = 9'h059;
  localparam logic [8:0] E_FILT   = 9'h06e;
  localparam logic [8:0] E_VAC    = 9'h0be;
  localparam logic [8:0] E_PWMON  = 9'h0cf;
  localparam logic [8:0] E_IOFS   = 9'h0d0;
  localparam logic [8:0] E_BLANK  = 9'h0d7;
  localparam logic [8:0] E_PEAK   = 9'h13f;
  localparam logic [8:0] E_ADOFS  = 9'h152;
  localparam logic [8:0] E_ADGAIN = 9'h153;
  localparam logic [8:0] E_IFB    = 9'h169;
  localparam logic [8:0] E_VOFS   = 9'h1b6;
  localparam logic [8:0] E_AC_INPUT_CURRENT   = 9'h1bb;
  localparam logic [8:0] E_RCP    = 9'h1c4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [11:0] acVolt;
    logic [11:0] dcVolt;
    logic [11:0] acCurr;
    logic [11:0] curA;
    logic [11:0] curB;
    logic [11:0] refHMeas;
    logic [11:0] refLMeas;
  } pfcp_adc_t;

  typedef struct packed {
    logic [11:0] uvThr;
    logic [11:0] ovThr;
    logic [15:0] uvTime;
    logic [15:0] ovTime;
    logic [15:0] goodTime;
    logic [11:0] under_voltage_level;
    logic [11:0] over_voltage_level;
    logic [11:0] hyst;
    logic [11:0] minPulse;
    logic [11:0] vdcNominal;
    logic [11:0] refHIdeal;
    logic [11:0] refLIdeal;
    logic        legShunt;
  } pfcp_cfg_t;

endpackage : pfcp_pkg

// [src/pfcp_time_qual.sv]
// Persistence qualifier: a condition counted in PWM cycles against a threshold.
// Assumes tick is a one-cycle pulse per motor PWM cycle.
`timescale 1ns/1ns
`default_nettype none
module pfcp_time_qual (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Condition
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [15:0] thr,
  // Result
  output var  logic        met
);
  import pfcp_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        met;
  } pfcp_qual_t;

  pfcp_qual_t s;
  pfcp_qual_t next_s;

  always_comb begin
    next_s = s;
    if (!cond) begin
      next_s.cnt = 16'h0000;
    end else if (tick && s.cnt != 16'hffff) begin
      next_s.cnt = s.cnt + 16'h0001;
    end
    next_s.met = cond && (next_s.cnt >= thr);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign met = s.met;
endmodule : pfcp_time_qual
`default_nettype wire

// [src/pfcp_lpf.sv]
// First-order low-pass on the rectified AC voltage, one step per PWM cycle.
// Assumes tick at the motor PWM rate; a shift of 2 gives about a quarter of that.
`timescale 1ns/1ns
`default_nettype none
module pfcp_lpf (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Sample
  input  wire logic        tick,
  input  wire logic [11:0] x,
  // Filtered value
  output var  logic [11:0] y
);
  import pfcp_pkg::*;

  typedef struct packed {
    logic [15:0] acc;
  } pfcp_lpf_t;

  pfcp_lpf_t          s;
  pfcp_lpf_t          next_s;
  logic signed [16:0] diff;

  always_comb begin
    next_s = s;
    diff   = $signed({1'b0, x, 4'h0}) - $signed({1'b0, s.acc});
    if (tick) begin
      next_s.acc = s.acc + 16'(diff >>> LPF_SHIFT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign y = s.acc[15:LPF_FRAC];
endmodule : pfcp_lpf
`default_nettype wire

// [src/pfcp_status_bank.sv]
// PFC protection status bank: computes status words and serves host and engine reads.
// Assumes engine strobes are single cycles and samples are steady when strobed.
`timescale 1ns/1ns
`default_nettype none
module pfcp_status_bank #(
  parameter int PEAK_CYC = pfcp_pkg::PEAK_CYCLES
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Engine timing and samples
  input  wire logic                pwmTick,
  input  wire pfcp_pkg::pfcp_adc_t adc,
  input  wire pfcp_pkg::pfcp_cfg_t cfg,
  // Engine control
  input  wire logic                pfcEnableA,
  input  wire logic                busCompensationEnable,
  input  wire logic                pfcStop,
  input  wire logic [11:0]         pfcPwmCmd,
  input  wire logic                partialMode,
  input  wire logic                offsetCal,
  input  wire logic                adcCal,
  input  wire logic                pfcStoppedBeforeStart,
  // Host port
  input  wire logic [15:0]         hostAddr,
  input  wire logic                hostRd,
  input  wire logic                hostWr,
  input  wire logic [15:0]         hostWdata,
  output var  logic [15:0]         hostRdata,
  // Engine port
  input  wire logic [8:0]          engAddr,
  input  wire logic                engRd,
  output var  logic [15:0]         engRdata,
  // Control outputs
  output var  logic                pfcPwmGate,
  output var  logic [15:0]         busReference,
  output var  logic [15:0]         busCompFactor
);
  import pfcp_pkg::*;

  // ==========================================================
  // Address decode
  function automatic pfcp_reg_t hostIndex(input logic [15:0] a);
    unique case (a)
      H_STATUS: hostIndex = R_STATUS;
      H_FILT:   hostIndex = R_FILT;
      H_VAC:    hostIndex = R_VAC;
      H_PWMON:  hostIndex = R_PWMON;
      H_IOFS:   hostIndex = R_IOFS;
      H_BLANK:  hostIndex = R_BLANK;
      H_PEAK:   hostIndex = R_PEAK;
      H_ADOFS:  hostIndex = R_ADOFS;
      H_ADGAIN: hostIndex = R_ADGAIN;
      H_IFB:    hostIndex = R_IFB;
      H_VOFS:   hostIndex = R_VOFS;
      H_AC_INPUT_CURRENT:   hostIndex = R_AC_INPUT_CURRENT;
      H_RCP:    hostIndex = R_RCP;
      default:  hostIndex = R_NONE;
    endcase
  endfunction : hostIndex

  function automatic pfcp_reg_t engIndex(input logic [8:0] a);
    unique case (a)
      E_STATUS: engIndex = R_STATUS;
      E_FILT:   engIndex = R_FILT;
      E_VAC:    engIndex = R_VAC;
      E_PWMON:  engIndex = R_PWMON;
      E_IOFS:   engIndex = R_IOFS;
      E_BLANK:  engIndex = R_BLANK;
      E_PEAK:   engIndex = R_PEAK;
      E_ADOFS:  engIndex = R_ADOFS;
      E_ADGAIN: engIndex = R_ADGAIN;
      E_IFB:    engIndex = R_IFB;
      E_VOFS:   engIndex = R_VOFS;
      E_AC_INPUT_CURRENT:   engIndex = R_AC_INPUT_CURRENT;
      E_RCP:    engIndex = R_RCP;
      default:  engIndex = R_NONE;
    endcase
  endfunction : engIndex

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] ifbOfs;
    logic [15:0] dc_bus_reciprocal;
    logic [15:0] adGain;
    logic [15:0] adOfs;
    logic [15:0] vac;
    logic [15:0] vacFilt;
    logic [15:0] ac_peak_voltage;
    logic [15:0] ac_input_current;
    logic [15:0] vacOfs;
    logic [15:0] ipfcOfs;
    logic        pwmOn;
    logic        blank;
    logic [2:0]  acStat;
    logic [11:0] peakMax;
    logic [21:0] peakCnt;
    logic        initDone;
    logic [15:0] busRef;
    logic [15:0] compFactor;
    logic [15:0] hostRdata;
    logic [15:0] engRdata;
  } pfcp_bank_t;

  pfcp_bank_t s;
  pfcp_bank_t next_s;

  function automatic logic [15:0] regRead(input pfcp_reg_t i, input pfcp_bank_t b);
    unique case (i)
      R_STATUS: regRead = {13'h0000, b.acStat};
      R_FILT:   regRead = b.vacFilt;
      R_VAC:    regRead = b.vac;
      R_PWMON:  regRead = {15'h0000, b.pwmOn};
      R_IOFS:   regRead = b.ipfcOfs;
      R_BLANK:  regRead = {15'h0000, b.blank};
      R_PEAK:   regRead = b.ac_peak_voltage;
      R_ADOFS:  regRead = b.adOfs;
      R_ADGAIN: regRead = b.adGain;
      R_IFB:    regRead = b.ifbOfs;
      R_VOFS:   regRead = b.vacOfs;
      R_AC_INPUT_CURRENT:   regRead = b.ac_input_current;
      R_RCP:    regRead = b.dc_bus_reciprocal;
      default:  regRead = 16'h0000;
    endcase
  endfunction : regRead

  // ==========================================================
  // Filter and qualifiers
  logic [11:0] filt;
  logic        uvMet;
  logic        ovMet;
  logic        goodMet;
  logic        uvNow;
  logic        ovNow;

  pfcp_lpf u_lpf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (pwmTick),
    .x        (s.vac[11:0]),
    .y        (filt)
  );

  assign uvNow = filt < cfg.uvThr;
  assign ovNow = filt > cfg.ovThr;

  pfcp_time_qual u_uv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (pwmTick),
    .cond     (uvNow),
    .thr      (cfg.uvTime),
    .met      (uvMet)
  );

  pfcp_time_qual u_ov (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (pwmTick),
    .cond     (ovNow),
    .thr      (cfg.ovTime),
    .met      (ovMet)
  );

  pfcp_time_qual u_good (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (pwmTick),
    .cond     (!uvNow && !ovNow),
    .thr      (cfg.goodTime),
    .met      (goodMet)
  );

  // ==========================================================
  // Arithmetic helpers
  logic signed [12:0] acCentred;
  logic [12:0]        acAbs;
  logic [23:0]        rcpNum;
  logic [23:0]        rcpQ;
  logic [11:0]        idealSpan;
  logic [11:0]        measSpan;
  logic [21:0]        gainQ;
  logic [11:0]        gainNew;
  logic [23:0]        measScaled;
  logic signed [15:0] ofsQ;
  logic signed [13:0] curMean;
  logic [12:0]        peakLo;
  logic [11:0]        peakHi;
  logic [12:0]        peakClamp;
  logic [21:0]        peakLast;

  always_comb begin
    acCentred  = $signed({1'b0, adc.acVolt}) - $signed({1'b0, MID_BIAS});
    acAbs      = acCentred[12] ? 13'(-acCentred) : acCentred[12:0];
    rcpNum     = {cfg.vdcNominal, 12'h000};
    rcpQ       = (adc.dcVolt == 12'h000) ? 24'hffffff : rcpNum / {12'h000, adc.dcVolt};
    idealSpan  = cfg.refHIdeal - cfg.refLIdeal;
    measSpan   = adc.refHMeas - adc.refLMeas;
    gainQ      = (measSpan == 12'h000) ? 22'h3fffff
                 : {idealSpan, 10'h000} / {10'h000, measSpan};
    gainNew    = (gainQ > 22'(GAIN_MAX)) ? GAIN_MAX[11:0] : gainQ[11:0];
    measScaled = adc.refLMeas * gainNew;
    ofsQ       = $signed({4'h0, cfg.refLIdeal}) - $signed({2'b00, measScaled[23:10]});
    // Leg shunt averages both channels before removing the mid bias
    curMean    = cfg.legShunt
                 ? ($signed({2'b00, adc.curA}) + $signed({2'b00, adc.curB})) >>> 1
                 : $signed({2'b00, adc.curA});
    peakLo     = {1'b0, cfg.under_voltage_level} + {3'b000, cfg.under_voltage_level[11:2]};
    peakHi     = cfg.over_voltage_level - {5'h00, cfg.over_voltage_level[11:5]};
    peakLast   = 22'(PEAK_CYC - 1);
    if ({1'b0, s.peakMax} < peakLo) begin
      peakClamp = peakLo;
    end else if (s.peakMax > peakHi) begin
      peakClamp = {1'b0, peakHi};
    end else begin
      peakClamp = {1'b0, s.peakMax};
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;

    // Per-cycle sample registers
    next_s.vac     = (acAbs > 13'(VAC_MAX)) ? VAC_MAX : {3'b000, acAbs};
    next_s.vacFilt = {4'h0, filt};
    next_s.ac_input_current    = {4'h0, adc.acCurr};

    // Bus reciprocal, held to its documented span
    next_s.dc_bus_reciprocal = (rcpQ > 24'(RCP_MAX)) ? RCP_MAX : rcpQ[15:0];
    // Unity factor when compensation is off so the regulator is unaffected
    next_s.compFactor = busCompensationEnable ? s.dc_bus_reciprocal : RCP_UNITY;

    if (offsetCal) begin
      next_s.ifbOfs = 16'(curMean - $signed({2'b00, MID_BIAS}));
      next_s.vacOfs = {4'h0, adc.acVolt - adc.dcVolt};
      if (pfcStoppedBeforeStart) begin
        next_s.ipfcOfs = {4'h0, adc.acCurr};
      end
    end

    // First capture happens once, on the first cycle out of reset
    if (!s.initDone) begin
      next_s.initDone = 1'b1;
      next_s.ipfcOfs  = {4'h0, adc.acCurr};
    end

    if (adcCal) begin
      next_s.adGain = {4'h0, gainNew};
      if (ofsQ > $signed(OFS_MAX)) begin
        next_s.adOfs = OFS_MAX;
      end else if (ofsQ < $signed(OFS_MIN)) begin
        next_s.adOfs = OFS_MIN;
      end else begin
        next_s.adOfs = ofsQ;
      end
    end

    // Peak window: max of filtered value, published at window end
    if (s.peakCnt == peakLast) begin
      next_s.peakCnt = 22'h000000;
      next_s.peakMax = filt;
      next_s.ac_peak_voltage = {3'b000, peakClamp};
    end else begin
      next_s.peakCnt = s.peakCnt + 22'h000001;
      if (filt > s.peakMax) begin
        next_s.peakMax = filt;
      end
    end

    // Partial mode reference; floors at zero rather than wrapping
    if (partialMode) begin
      next_s.busRef = (s.ac_peak_voltage > {4'h0, cfg.hyst})
                      ? s.ac_peak_voltage - {4'h0, cfg.hyst} : 16'h0000;
    end else begin
      next_s.busRef = 16'h0000;
    end

    if (pwmTick) begin
      next_s.blank = s.vac[11:0] > adc.dcVolt;
    end

    next_s.acStat[ST_UV]  = uvMet;
    next_s.acStat[ST_OV]  = ovMet;
    next_s.acStat[ST_ABN] = !goodMet;

    next_s.pwmOn = pfcEnableA
                   && !pfcStop && !s.blank
                   && (pfcPwmCmd >= cfg.minPulse)
                   && !s.acStat[ST_UV] && !s.acStat[ST_OV];

    // Host writes land nowhere; the bank is read-only from that side
    if (hostRd) begin
      next_s.hostRdata = regRead(hostIndex(hostAddr), s);
    end
    if (engRd) begin
      next_s.engRdata = regRead(engIndex(engAddr), s);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign hostRdata     = s.hostRdata;
  assign engRdata      = s.engRdata;
  assign pfcPwmGate    = s.pwmOn;
  assign busReference  = s.busRef;
  assign busCompFactor = s.compFactor;

endmodule : pfcp_status_bank
`default_nettype wire

// [tb/pfcp_status_properties.sv]
// Assertions on the ports of the PFC status readback bank.
// Assumes it is bound to pfcp_status_bank and that one clock drives everything.
`timescale 1ns/1ns
`default_nettype none
module pfcp_status_properties (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // Engine inputs
  input wire pfcp_pkg::pfcp_adc_t adc,
  input wire pfcp_pkg::pfcp_cfg_t cfg,
  input wire logic                pfcEnableA,
  input wire logic                busCompensationEnable,
  input wire logic                pfcStop,
  input wire logic [11:0]         pfcPwmCmd,
  input wire logic                partialMode,
  // Read ports
  input wire logic [15:0]         hostAddr,
  input wire logic                hostRd,
  input wire logic [15:0]         hostRdata,
  input wire logic [8:0]          engAddr,
  input wire logic                engRd,
  input wire logic [15:0]         engRdata,
  // Control outputs
  input wire logic                pfcPwmGate,
  input wire logic [15:0]         busReference,
  input wire logic [15:0]         busCompFactor
);
  import pfcp_pkg::*;
  // ==========
  // Helpers
  // Outputs are zero on the first edge after release, so skip that edge
  logic live;
  always_ff @(posedge core_clk) begin
    live <= rst_n;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Properties
  comp_unity_a: assert property (
    live && !busCompensationEnable |=> busCompFactor == RCP_UNITY)
    else $error("compensation factor not unity while disabled");
  comp_clamp_a: assert property (
    (live && busCompensationEnable && adc.dcVolt == 12'h000) [*3] |=> busCompFactor == RCP_MAX)
    else $error("reciprocal not clamped at zero bus");
  stop_gate_a: assert property (
    live && pfcStop |=> !pfcPwmGate)
    else $error("gate on after stop");
  enable_gate_a: assert property (
    live && !pfcEnableA |=> !pfcPwmGate)
    else $error("gate on without enable");
  pulse_gate_a: assert property (
    live && pfcPwmCmd < cfg.minPulse |=> !pfcPwmGate)
    else $error("gate on with short pulse command");
  unmapped_read_a: assert property (
    live && hostRd && hostAddr[0] |=> hostRdata == REG_RESET)
    else $error("odd address read not zero");
  rdata_hold_a: assert property (
    live && !hostRd |=> $stable(hostRdata))
    else $error("host read data moved without a read");
  busref_idle_a: assert property (
    live && !partialMode |=> busReference == REG_RESET)
    else $error("bus reference set outside partial mode");
  gate_mirror_a: assert property (
    live && engRd && engAddr == E_PWMON |=> engRdata == {15'h0000, $past(pfcPwmGate)})
    else $error("engine read differs from gate");
endmodule : pfcp_status_properties

bind pfcp_status_bank pfcp_status_properties u_props (
  .core_clk, .rst_n, .adc, .cfg, .pfcEnableA, .busCompensationEnable, .pfcStop,
  .pfcPwmCmd, .partialMode, .hostAddr, .hostRd, .hostRdata, .engAddr, .engRd,
  .engRdata, .pfcPwmGate, .busReference, .busCompFactor
);
`default_nettype wire

// [tb/pfcp_host_model.sv]
// Host side model: single-cycle reads and writes on the status bank.
// Assumes the bank answers one clock after the strobe edge.
`timescale 1ns/1ns
`default_nettype none
module pfcp_host_model (
  // Clock
  input  wire logic        core_clk,
  // Host bus
  output var  logic [15:0] hostAddr,
  output var  logic        hostRd,
  output var  logic        hostWr,
  output var  logic [15:0] hostWdata,
  input  wire logic [15:0] hostRdata
);
  // ==========
  // Bus cycle
  initial begin
    hostAddr  = 16'h0000;
    hostRd    = 1'b0;
    hostWr    = 1'b0;
    hostWdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] w,
                        output logic [15:0] d);
    @(posedge core_clk);
    #1;
    hostAddr  = a;
    hostWdata = w;
    hostRd    = !wr;
    hostWr    = wr;
    @(posedge core_clk);
    #1;
    d         = hostRdata;
    hostRd    = 1'b0;
    hostWr    = 1'b0;
    // Released lines inverted so stale values never look valid
    hostAddr  = ~a;
    hostWdata = ~w;
  endtask : access
endmodule : pfcp_host_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the PFC status readback bank.
// Assumes a shortened peak window and a PWM tick every fourth clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pfcp_pkg::*;
  // ==========
  // Signals
  localparam int PK = 200;
  localparam logic [15:0] HA [12] = '{H_STATUS, H_FILT, H_VAC, H_PWMON, H_IOFS, H_BLANK,
                                      H_PEAK, H_ADOFS, H_ADGAIN, H_VOFS, H_AC_INPUT_CURRENT, H_RCP};
  localparam logic [8:0]  EA [12] = '{E_STATUS, E_FILT, E_VAC, E_PWMON, E_IOFS, E_BLANK,
                                      E_PEAK, E_ADOFS, E_ADGAIN, E_VOFS, E_AC_INPUT_CURRENT, E_RCP};
  localparam logic [11:0] AC [3] = '{12'h900, 12'h000, 12'h6f0};
  localparam logic [11:0] DC [3] = '{12'h400, 12'h800, 12'h000};
  localparam logic [15:0] VX [3] = '{16'h0100, 16'h07ff, 16'h0110};
  localparam logic [15:0] RX [3] = '{16'h1000, 16'h0800, 16'h15d5};
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        tickOn   = 1'b0;
  logic        pwmTick  = 1'b0;
  logic [1:0]  tickCnt  = 2'h0;
  pfcp_adc_t   adc;
  pfcp_cfg_t   cfg;
  logic        pfcEnableA, busCompensationEnable, pfcStop, partialMode;
  logic        offsetCal, adcCal, pfcStoppedBeforeStart, engRd, hostRd, hostWr, pfcPwmGate;
  logic [11:0] pfcPwmCmd;
  logic [8:0]  engAddr;
  logic [15:0] hostAddr, hostWdata, hostRdata, engRdata, busReference, busCompFactor;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  // ==========
  // Clock, tick and instances
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tickCnt <= #1 tickCnt + 2'h1;
    pwmTick <= #1 tickOn && (tickCnt == 2'h3);
  end
  pfcp_host_model host (.core_clk, .hostAddr, .hostRd, .hostWr, .hostWdata, .hostRdata);
  pfcp_status_bank #(.PEAK_CYC(PK)) dut (
    .core_clk, .rst_n, .pwmTick, .adc, .cfg, .pfcEnableA, .busCompensationEnable,
    .pfcStop, .pfcPwmCmd, .partialMode, .offsetCal, .adcCal, .pfcStoppedBeforeStart,
    .hostAddr, .hostRd, .hostWr, .hostWdata, .hostRdata, .engAddr, .engRd, .engRdata,
    .pfcPwmGate, .busReference, .busCompFactor
  );
  // ==========
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic hr(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.access(1'b0, a, 16'h0000, d);
    check(d, exp);
  endtask : hr
  task automatic er(input logic [8:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    #1;
    engAddr = a;
    engRd   = 1'b1;
    cyc(1);
    engRd   = 1'b0;
    engAddr = ~a;
    check(engRdata, exp);
  endtask : er
  task automatic strobe(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : strobe
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========
  // Watchdog: a hang counts as a mismatch
  initial begin
    #400_000;
    n_mismatch++;
    report_and_stop();
  end
  // ==========
  // Sequence
  initial begin
    logic [15:0] d;
    adc = '{acVolt: 12'h800, dcVolt: 12'h400, default: 12'h000};
    cfg = '{uvThr: 12'h080, ovThr: 12'h200, uvTime: 16'h0003, ovTime: 16'h0003,
            goodTime: 16'h0004, under_voltage_level: 12'h100, over_voltage_level: 12'h200, hyst: 12'h020,
            minPulse: 12'h010, vdcNominal: 12'h400, refHIdeal: 12'hc00,
            refLIdeal: 12'h400, legShunt: 1'b1};
    {pfcEnableA, busCompensationEnable, pfcStop, partialMode} = 4'h0;
    {offsetCal, adcCal, pfcStoppedBeforeStart, engRd} = 4'h0;
    pfcPwmCmd = 12'h100;
    engAddr   = 9'h000;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    // Reset values, both spaces, before the first peak window closes
    for (int i = 0; i < 12; i++) begin
      hr(HA[i], (i == 0) ? 16'h0001 : (i == 11) ? 16'h1000 : 16'h0000);
      er(EA[i], (i == 0) ? 16'h0001 : (i == 11) ? 16'h1000 : 16'h0000);
    end
    host.access(1'b1, H_STATUS, 16'hffff, d);
    hr(H_STATUS, 16'h0001);
    hr(16'h80b3, 16'h0000);
    er(9'h000, 16'h0000);
    // Converter correction, ideal and degenerate span
    adc.refHMeas = 12'hc05;
    adc.refLMeas = 12'h405;
    strobe(adcCal);
    hr(H_ADGAIN, 16'h0400);
    er(E_ADOFS, 16'hfffb);
    adc.refHMeas = 12'h405;
    strobe(adcCal);
    hr(H_ADGAIN, 16'h0fff);
    hr(H_ADOFS, 16'hfc00);
    // Offset correction stage
    adc = '{curA: 12'h810, curB: 12'h820, acVolt: 12'h100, dcVolt: 12'h200,
            acCurr: 12'h123, default: 12'h405};
    pfcStoppedBeforeStart = 1'b1;
    strobe(offsetCal);
    hr(H_IFB, 16'h0018);
    hr(H_VOFS, 16'h0f00);
    hr(H_IOFS, 16'h0123);
    cfg.legShunt = 1'b0;
    adc.curA = 12'h7f0;
    adc.acCurr = 12'h456;
    pfcStoppedBeforeStart = 1'b0;
    strobe(offsetCal);
    hr(H_IFB, 16'hfff0);
    er(E_IFB, 16'hfff0);
    hr(H_IOFS, 16'h0123);
    hr(H_AC_INPUT_CURRENT, 16'h0456);
    // Rectified voltage and bus reciprocal
    busCompensationEnable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      adc.acVolt = AC[i];
      adc.dcVolt = DC[i];
      cyc(3);
      hr(H_VAC, VX[i]);
      hr(H_RCP, RX[i]);
      check(busCompFactor, RX[i]);
    end
    busCompensationEnable = 1'b0;
    // Normal input, then the stop, short pulse and blanking gating causes
    adc.acVolt = 12'h900;
    adc.dcVolt = 12'h400;
    tickOn = 1'b1;
    cyc(200);
    hr(H_STATUS, 16'h0000);
    pfcEnableA = 1'b1;
    cyc(4);
    hr(H_PWMON, 16'h0001);
    check({15'h0000, pfcPwmGate}, 16'h0001);
    pfcStop = 1'b1;
    cyc(2);
    er(E_PWMON, 16'h0000);
    pfcStop = 1'b0;
    pfcPwmCmd = 12'h00f;
    cyc(2);
    hr(H_PWMON, 16'h0000);
    pfcPwmCmd = 12'h100;
    adc.dcVolt = 12'h0ff;
    cyc(8);
    hr(H_BLANK, 16'h0001);
    hr(H_PWMON, 16'h0000);
    adc.dcVolt = 12'h100;
    cyc(8);
    hr(H_BLANK, 16'h0000);
    hr(H_PWMON, 16'h0001);
    // Under and over voltage with partial mode reference
    partialMode = 1'b1;
    adc.acVolt = 12'h800;
    cyc(450);
    hr(H_STATUS, 16'h0003);
    hr(H_FILT, 16'h0000);
    hr(H_PEAK, 16'h0140);
    check(busReference, 16'h0120);
    hr(H_PWMON, 16'h0000);
    adc.acVolt = 12'hc00;
    cyc(450);
    hr(H_STATUS, 16'h0005);
    hr(H_PEAK, 16'h01f0);
    check(busReference, 16'h01d0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
